/* File: hdl/protect_cfg.svh */
// constants for the motor process protection monitor
`ifndef PROTECT_CFG_SVH
`define PROTECT_CFG_SVH
// field widths
`define PCT_W 10
`define SEC_W 10
`define UL_DLY_W 6
`define TWAIT_W 12
// clock rate and one-second time base
`define CLK_FREQ_HZ 200000000
`define TICK_S 1
// underload supervision
`define UL_THR_MIN 10'h014
`define UL_THR_MAX 10'h064
`define UL_THR_DEF 10'h03C
`define UL_DLY_MAX 6'h3C
`define UL_DLY_DEF 6'h3C
`define UL_HYST_PCT 10'h00A
// start supervision
`define START_LIM_OFF 10'h000
`define START_LIM_MIN 10'h00A
`define START_LIM_MAX 10'h3E7
`define START_END_CUR_PCT 10'h0C8
`define START_DUR_MAX 10'h3E8
// restart delay and thermal wait
`define RESTART_MAX 10'h3E7
`define RESTART_DEF 10'h002
`define TWAIT_MAX 12'hE10
`endif

/* File: hdl/protect_pkg.sv */
// types shared by the motor process protection monitor
`include "protect_cfg.svh"
package protect_pkg;
   typedef enum logic [1:0] {RESP_IGNORE = 2'h0, RESP_FREEWHEEL = 2'h1,
      RESP_DECEL = 2'h2, RESP_BRAKE = 2'h3} ul_resp_t;
   typedef enum logic [1:0] {STOP_FREEWHEEL = 2'h0, STOP_DECEL = 2'h1,
      STOP_BRAKE = 2'h2} stop_t;
   typedef enum logic [1:0] {WIRE_HARDWIRED = 2'h0, WIRE_2_LEVEL = 2'h1,
      WIRE_2_TRANS = 2'h2, WIRE_3 = 2'h3} wire_t;
   // PH_NONE: automatic as a setting, nothing recognised as a reading
   typedef enum logic [1:0] {PH_NONE = 2'h0, PH_123 = 2'h1, PH_321 = 2'h2} phase_t;
   typedef enum logic [3:0] {MS_IDLE = 4'h1, MS_START = 4'h2, MS_RUN = 4'h4,
      MS_STOP = 4'h8} mstate_t;
   typedef struct packed {
      logic underload_enable;
      logic [`PCT_W-1:0] underload_torque_threshold;
      logic [`UL_DLY_W-1:0] underload_detect_delay;
      ul_resp_t underload_response_select;
      logic [`SEC_W-1:0] underload_hold_time;
      logic [`SEC_W-1:0] start_time_limit;
      logic long_start_response_select; // 0 freewheel, 1 deceleration
      phase_t phase_order_setting;
      logic [`SEC_W-1:0] restart_delay_time;
      stop_t stop_type;
      wire_t wire_mode;
      logic thermal_start_inhibit_enable;
      logic [`PCT_W-1:0] thermal_threshold;
   } settings_t;
   typedef struct packed {
      logic bypassed;
      logic full_voltage;
      logic [`PCT_W-1:0] torque_pct;
      logic [`PCT_W-1:0] current_pct;
      phase_t phase_seq;
      logic run_cmd;
      logic stop_cmd;
      logic decel_done;
      logic motor_stopped;
      logic [`PCT_W-1:0] thermal_state_pct;
      logic [`TWAIT_W-1:0] thermal_wait_s;
   } meas_t;
   typedef struct packed {
      logic underload_warning_flag;
      logic underload_error_flag;
      logic long_start_error_flag;
      logic phase_inversion_error;
      phase_t detected_phase_order;
      logic [`SEC_W-1:0] measured_start_duration;
      logic wait_restart;
      logic thermal_inhibit;
      logic [`TWAIT_W-1:0] thermal_wait_remaining;
   } status_t;
   typedef struct packed {
      logic drive_on;
      logic decel_req;
      logic brake_req;
      logic start_pulse;
   } drive_t;
endpackage : protect_pkg

/* File: hdl/sec_tick.sv */
// one-second tick generator with synchronous restart
`timescale 1ns/1ps
`default_nettype none
module sec_tick #(
   parameter int unsigned CYCLES = 200000000
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic clr,
   output logic tick_r
);
   localparam int unsigned CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
   localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
   logic [CW-1:0] cnt_r;
   // count cycles, pulse in the cycle after the last one of each second
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cnt_r <= '0;
         tick_r <= 1'b0;
      end else if (clr) begin
         cnt_r <= '0;
         tick_r <= 1'b0;
      end else begin
         tick_r <= (cnt_r == LAST);
         cnt_r <= (cnt_r == LAST) ? '0 : cnt_r + CW'(1);
      end
   end
endmodule : sec_tick
`default_nettype wire

/* File: hdl/motor_process_protection_monitor.sv */
// motor process protection monitor: underload, start time, phase order, restart
`timescale 1ns/1ps
`default_nettype none
`include "protect_cfg.svh"
module motor_process_protection_monitor #(
   parameter int unsigned TICK_CYCLES = `TICK_S * `CLK_FREQ_HZ
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire protect_pkg::settings_t cfg,
   input wire protect_pkg::meas_t meas_in,
   input wire logic error_clear,
   output protect_pkg::status_t status_r,
   output protect_pkg::drive_t drive_r
);
   import protect_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // input synchronisers
   meas_t meas_s1_r;
   meas_t meas_r;
   logic run_prev_r;
   // two stages before any logic looks at the pins
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         meas_s1_r <= '0;
         meas_r <= '0;
         run_prev_r <= 1'b0;
      end else begin
         meas_s1_r <= meas_in;
         meas_r <= meas_s1_r;
         run_prev_r <= meas_r.run_cmd;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // declarations
   mstate_t state_r;
   mstate_t state_nxt;
   stop_t kind_r;
   stop_t kind_nxt;
   logic pend_ul_r;
   logic pend_ul_nxt;
   logic pend_ls_r;
   logic pend_ls_nxt;
   logic tick;
   logic start_go;
   logic restart_go;
   logic set_ul_err;
   logic set_ls_err;
   logic ul_trip;
   logic ls_trip;
   logic [`PCT_W-1:0] ul_thr;
   logic [`UL_DLY_W-1:0] ul_dly;
   logic [`SEC_W-1:0] ls_lim;
   logic [`SEC_W-1:0] rs_dly;
   logic [`UL_DLY_W-1:0] ul_cnt_r;
   logic ul_det_r;
   logic [`SEC_W-1:0] hold_cnt_r;
   logic [`SEC_W-1:0] start_cnt_r;
   logic [`SEC_W-1:0] rs_cnt_r;
   logic learned_v_r;
   phase_t learned_r;
   phase_t expect_ph;
   logic level_mode;
   logic run_req;
   logic allowed;
   logic ul_active;
   logic ul_below;
   logic ul_above;
   logic start_end;
   logic any_err;

   ////////////////////////////////////////////////////////////////////////////
   // second time base, restarted whenever a start or restart timer begins
   sec_tick #(
      .CYCLES(TICK_CYCLES)
   ) u_tick (
      .sys_clk(sys_clk),
      .rst(rst),
      .clr(start_go | restart_go),
      .tick_r(tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // settings held inside their legal ranges
   always_comb begin
      ul_thr = cfg.underload_torque_threshold;
      if (ul_thr < `UL_THR_MIN) ul_thr = `UL_THR_MIN;
      if (ul_thr > `UL_THR_MAX) ul_thr = `UL_THR_MAX;
      ul_dly = (cfg.underload_detect_delay > `UL_DLY_MAX) ? `UL_DLY_MAX
         : cfg.underload_detect_delay;
      ls_lim = cfg.start_time_limit;
      if (ls_lim != `START_LIM_OFF && ls_lim < `START_LIM_MIN) ls_lim = `START_LIM_MIN;
      if (ls_lim > `START_LIM_MAX) ls_lim = `START_LIM_MAX;
      rs_dly = (cfg.restart_delay_time > `RESTART_MAX) ? `RESTART_MAX
         : cfg.restart_delay_time;
   end

   ////////////////////////////////////////////////////////////////////////////
   // run command qualification
   assign level_mode = (cfg.wire_mode == WIRE_HARDWIRED) || (cfg.wire_mode == WIRE_2_LEVEL);
   assign any_err = status_r.underload_error_flag | status_r.long_start_error_flag
      | status_r.phase_inversion_error;
   // restart delay and thermal inhibit both hold the start off
   assign allowed = !status_r.wait_restart && !status_r.thermal_inhibit && !any_err;
   // level command waits out the delay, an edge during the delay is lost
   assign run_req = level_mode ? meas_r.run_cmd
      : (meas_r.run_cmd && !run_prev_r);
   assign start_go = (state_r == MS_IDLE) && run_req && allowed && !meas_r.stop_cmd;
   // a start ends at full voltage with current under twice nominal
   assign start_end = meas_r.full_voltage && (meas_r.current_pct < `START_END_CUR_PCT);
   assign ls_trip = (state_r == MS_START) && (ls_lim != `START_LIM_OFF)
      && (start_cnt_r >= ls_lim) && !start_end;

   ////////////////////////////////////////////////////////////////////////////
   // underload detection terms
   assign ul_active = cfg.underload_enable && meas_r.bypassed && (state_r == MS_RUN);
   assign ul_below = meas_r.torque_pct < ul_thr;
   assign ul_above = meas_r.torque_pct > (ul_thr + `UL_HYST_PCT);
   assign ul_trip = ul_active && ul_below && !ul_det_r && (ul_cnt_r >= ul_dly);

   // underload delay timer in whole seconds
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ul_cnt_r <= '0;
         ul_det_r <= 1'b0;
      end else if (!ul_active || ul_above) begin
         ul_cnt_r <= '0;
         ul_det_r <= 1'b0;
      end else if (ul_trip) begin
         ul_det_r <= 1'b1;
      end else if (ul_below && tick && ul_cnt_r < `UL_DLY_MAX) begin
         ul_cnt_r <= ul_cnt_r + `UL_DLY_W'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // motor sequence: start, run, controlled stop
   always_comb begin
      state_nxt = state_r;
      kind_nxt = kind_r;
      pend_ul_nxt = pend_ul_r;
      pend_ls_nxt = pend_ls_r;
      restart_go = 1'b0;
      set_ul_err = 1'b0;
      set_ls_err = 1'b0;
      case (state_r)
         MS_IDLE: begin
            pend_ul_nxt = 1'b0;
            pend_ls_nxt = 1'b0;
            if (start_go) state_nxt = MS_START;
         end
         MS_START: begin
            if (ls_trip && !cfg.long_start_response_select) begin
               set_ls_err = 1'b1;
               restart_go = 1'b1;
               state_nxt = MS_IDLE;
            end else if (ls_trip) begin
               pend_ls_nxt = 1'b1;
               kind_nxt = STOP_DECEL;
               state_nxt = MS_STOP;
            end else if (meas_r.stop_cmd) begin
               kind_nxt = cfg.stop_type;
               state_nxt = (cfg.stop_type == STOP_FREEWHEEL) ? MS_IDLE : MS_STOP;
               restart_go = (cfg.stop_type == STOP_FREEWHEEL);
            end else if (start_end) begin
               state_nxt = MS_RUN;
            end
         end
         MS_RUN: begin
            if (ul_trip && cfg.underload_response_select == RESP_FREEWHEEL) begin
               set_ul_err = 1'b1;
               restart_go = 1'b1;
               state_nxt = MS_IDLE;
            end else if (ul_trip && cfg.underload_response_select != RESP_IGNORE) begin
               pend_ul_nxt = 1'b1;
               kind_nxt = (cfg.underload_response_select == RESP_DECEL) ? STOP_DECEL
                  : STOP_BRAKE;
               state_nxt = MS_STOP;
            end else if (meas_r.stop_cmd) begin
               kind_nxt = cfg.stop_type;
               state_nxt = (cfg.stop_type == STOP_FREEWHEEL) ? MS_IDLE : MS_STOP;
               restart_go = (cfg.stop_type == STOP_FREEWHEEL);
            end
         end
         MS_STOP: begin
            // deceleration ends at its end time, braking at standstill
            if ((kind_r == STOP_DECEL && meas_r.decel_done)
               || (kind_r != STOP_DECEL && meas_r.motor_stopped)) begin
               restart_go = 1'b1;
               set_ul_err = pend_ul_r;
               set_ls_err = pend_ls_r;
               state_nxt = MS_IDLE;
            end
         end
         default: begin
            state_nxt = MS_IDLE;
         end
      endcase
   end

   // sequence registers
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_r <= MS_IDLE;
         kind_r <= STOP_FREEWHEEL;
         pend_ul_r <= 1'b0;
         pend_ls_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         kind_r <= kind_nxt;
         pend_ul_r <= pend_ul_nxt;
         pend_ls_r <= pend_ls_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // start duration counter, saturating
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         start_cnt_r <= '0;
      end else if (start_go) begin
         start_cnt_r <= '0;
      end else if (state_r == MS_START && tick && start_cnt_r < `START_DUR_MAX) begin
         start_cnt_r <= start_cnt_r + `SEC_W'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // restart delay counter and error hold counter
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rs_cnt_r <= '0;
      end else if (restart_go) begin
         rs_cnt_r <= rs_dly;
      end else if (tick && rs_cnt_r != '0) begin
         rs_cnt_r <= rs_cnt_r - `SEC_W'(1);
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         hold_cnt_r <= '0;
      end else if (set_ul_err) begin
         hold_cnt_r <= cfg.underload_hold_time;
      end else if (tick && hold_cnt_r != '0) begin
         hold_cnt_r <= hold_cnt_r - `SEC_W'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // phase order learning and expected order
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         learned_v_r <= 1'b0;
         learned_r <= PH_NONE;
      end else if (start_go && !learned_v_r && meas_r.phase_seq != PH_NONE) begin
         learned_v_r <= 1'b1;
         learned_r <= meas_r.phase_seq;
      end
   end
   assign expect_ph = (cfg.phase_order_setting != PH_NONE) ? cfg.phase_order_setting
      : (learned_v_r ? learned_r : PH_NONE);

   ////////////////////////////////////////////////////////////////////////////
   // warning and error flags, a set beats a clear in the same cycle
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         status_r.underload_warning_flag <= 1'b0;
      end else if (ul_trip && cfg.underload_response_select == RESP_IGNORE) begin
         status_r.underload_warning_flag <= 1'b1;
      end else if (!ul_active || ul_above) begin
         status_r.underload_warning_flag <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         status_r.underload_error_flag <= 1'b0;
      end else if (set_ul_err) begin
         status_r.underload_error_flag <= 1'b1;
      end else if (error_clear && hold_cnt_r == '0) begin
         status_r.underload_error_flag <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         status_r.long_start_error_flag <= 1'b0;
      end else if (set_ls_err) begin
         status_r.long_start_error_flag <= 1'b1;
      end else if (error_clear) begin
         status_r.long_start_error_flag <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         status_r.phase_inversion_error <= 1'b0;
      end else if (expect_ph != PH_NONE && meas_r.phase_seq != PH_NONE
         && meas_r.phase_seq != expect_ph) begin
         status_r.phase_inversion_error <= 1'b1;
      end else if (error_clear) begin
         status_r.phase_inversion_error <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // readouts
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         status_r.detected_phase_order <= PH_NONE;
         status_r.measured_start_duration <= '0;
         status_r.wait_restart <= 1'b0;
         status_r.thermal_inhibit <= 1'b0;
         status_r.thermal_wait_remaining <= '0;
      end else begin
         status_r.detected_phase_order <= (expect_ph != PH_NONE) ? meas_r.phase_seq
            : PH_NONE;
         if (state_r == MS_START && state_nxt != MS_START) begin
            status_r.measured_start_duration <= start_cnt_r;
         end
         status_r.wait_restart <= restart_go ? (rs_dly != '0)
            : (rs_cnt_r > `SEC_W'(1) || (rs_cnt_r == `SEC_W'(1) && !tick));
         status_r.thermal_inhibit <= cfg.thermal_start_inhibit_enable
            && (meas_r.thermal_state_pct >= cfg.thermal_threshold);
         if (!cfg.thermal_start_inhibit_enable) begin
            status_r.thermal_wait_remaining <= '0;
         end else begin
            status_r.thermal_wait_remaining <= (meas_r.thermal_wait_s > `TWAIT_MAX)
               ? `TWAIT_MAX : meas_r.thermal_wait_s;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // motor drive requests, registered from the next state
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         drive_r <= '0;
      end else begin
         drive_r.drive_on <= (state_nxt == MS_START) || (state_nxt == MS_RUN);
         drive_r.decel_req <= (state_nxt == MS_STOP) && (kind_nxt == STOP_DECEL);
         drive_r.brake_req <= (state_nxt == MS_STOP) && (kind_nxt == STOP_BRAKE);
         drive_r.start_pulse <= start_go;
      end
   end
endmodule : motor_process_protection_monitor
`default_nettype wire

/* File: testbench/protect_monitor.sv */
// assertion checker on the protection monitor ports
`timescale 1ns/1ps
`default_nettype none
module protect_monitor #(
   parameter int unsigned TICK_CYCLES = 20
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire protect_pkg::settings_t cfg,
   input wire protect_pkg::meas_t meas_in,
   input wire logic error_clear,
   input wire protect_pkg::status_t status_r,
   input wire protect_pkg::drive_t drive_r
);
   import protect_pkg::*;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   //////////////////////////////
   // starts only from rest, outside the restart wait and thermal hold
   a_start_no_wait: assert property (drive_r.start_pulse |-> !$past(status_r.wait_restart))
      else $error("start during restart wait");
   a_start_cool: assert property (drive_r.start_pulse |-> !$past(status_r.thermal_inhibit))
      else $error("start during thermal hold");
   a_start_fresh: assert property (drive_r.start_pulse |-> drive_r.drive_on && !$past(drive_r.drive_on))
      else $error("start pulse without fresh drive");
   // underload outcomes
   a_ul_err_stopped: assert property ($rose(status_r.underload_error_flag) |-> !drive_r.drive_on)
      else $error("underload error with drive on");
   a_ignore_no_err: assert property ($rose(status_r.underload_error_flag)
      |-> $past(cfg.underload_response_select) != RESP_IGNORE)
      else $error("underload error under ignore");
   a_ul_off_quiet: assert property (!cfg.underload_enable [*3] |-> !status_r.underload_warning_flag)
      else $error("underload warning while disabled");
   a_hold_keeps: assert property ($rose(status_r.underload_error_flag)
      && cfg.underload_hold_time != 10'h000 |=> status_r.underload_error_flag)
      else $error("underload error cleared during hold");
   // start supervision, thermal wait display and freewheel stop
   a_ls_off: assert property ($rose(status_r.long_start_error_flag)
      |-> $past(cfg.start_time_limit) != 10'h000)
      else $error("long start error while disabled");
   a_ls_coast: assert property ($rose(status_r.long_start_error_flag) |-> !drive_r.drive_on)
      else $error("long start error with drive on");
   a_dur_range: assert property (status_r.measured_start_duration <= 10'h3E8)
      else $error("start duration out of range");
   a_twait_off: assert property (!cfg.thermal_start_inhibit_enable [*2]
      |-> status_r.thermal_wait_remaining == 12'h000)
      else $error("thermal wait shown while disabled");
   a_free_stop: assert property (meas_in.stop_cmd && cfg.stop_type == STOP_FREEWHEEL [*5]
      |-> !drive_r.drive_on)
      else $error("freewheel stop left drive on");
endmodule : protect_monitor
bind motor_process_protection_monitor protect_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_mon (
   .sys_clk(sys_clk), .rst(rst), .cfg(cfg), .meas_in(meas_in), .error_clear(error_clear),
   .status_r(status_r), .drive_r(drive_r));
`default_nettype wire

/* File: testbench/motor_plant.sv */
// behavioural motor and mains model facing the protection monitor
`timescale 1ns/1ps
`default_nettype none
module motor_plant (
   input wire logic sys_clk,
   input wire protect_pkg::drive_t drive,
   input wire logic run,
   input wire logic stop,
   input wire logic full,
   input wire logic [9:0] torque,
   input wire protect_pkg::phase_t phase,
   input wire logic [9:0] heat,
   output protect_pkg::meas_t meas
);
   import protect_pkg::*;
   logic [2:0] decel_cnt_r = 3'h0;
   logic [2:0] brake_cnt_r = 3'h0;
   // stop ramps finish five cycles after they are requested
   always_ff @(posedge sys_clk) begin
      decel_cnt_r <= drive.decel_req ? decel_cnt_r + 3'(decel_cnt_r != 3'h5) : 3'h0;
      brake_cnt_r <= drive.brake_req ? brake_cnt_r + 3'(brake_cnt_r != 3'h5) : 3'h0;
   end
   // measured quantities follow the motor state
   always_comb begin
      meas = '0;
      meas.bypassed = drive.drive_on & full;
      meas.full_voltage = full;
      meas.torque_pct = torque;
      meas.current_pct = full ? 10'h064 : 10'h12C;
      meas.phase_seq = phase;
      meas.run_cmd = run;
      meas.stop_cmd = stop;
      meas.decel_done = decel_cnt_r == 3'h5;
      meas.motor_stopped = brake_cnt_r == 3'h5;
      meas.thermal_state_pct = heat;
      meas.thermal_wait_s = {heat, 2'h0};
   end
endmodule : motor_plant
`default_nettype wire

/* File: testbench/motor_process_protection_monitor_tb_top.sv */
// self-checking bench for the motor process protection monitor
`timescale 1ns/1ps
`default_nettype none
module motor_process_protection_monitor_tb_top;
   import protect_pkg::*;
   logic sys_clk;
   logic rst;
   logic error_clear;
   logic run;
   logic stop;
   logic full;
   logic [9:0] torque;
   logic [9:0] heat;
   phase_t phase;
   settings_t cfg;
   meas_t meas;
   status_t st;
   drive_t drv;
   int miscompares;
   int cmp_count;
   int n;
   //////////////////////////////
   motor_process_protection_monitor #(.TICK_CYCLES(20)) uut (.sys_clk(sys_clk), .rst(rst),
      .cfg(cfg), .meas_in(meas), .error_clear(error_clear), .status_r(st), .drive_r(drv));
   motor_plant u_plant (.sys_clk(sys_clk), .drive(drv), .run(run), .stop(stop), .full(full),
      .torque(torque), .phase(phase), .heat(heat), .meas(meas));
   // free running clock
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   //////////////////////////////
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic cyc(input int k);
      repeat (k) @(negedge sys_clk);
   endtask : cyc
   task automatic clr;
      error_clear = 1'b1;
      cyc(1);
      error_clear = 1'b0;
      cyc(2);
   endtask : clr
   // raise run and wait for the accepted start
   task automatic go;
      run = 1'b1;
      for (n = 0; n < 100 && !drv.start_pulse; n++) cyc(1);
      check(16'(drv.start_pulse), 16'h1);
      run = 1'b0;
   endtask : go
   task automatic halt;
      stop = 1'b1;
      run = 1'b0;
      cyc(30);
      stop = 1'b0;
      cyc(4);
   endtask : halt
   //////////////////////////////
   task automatic t_phase;
      check(16'(st.detected_phase_order), 16'(PH_NONE));
      cfg.phase_order_setting = PH_123;
      phase = PH_321;
      cyc(8);
      check(16'(st.phase_inversion_error), 16'h1);
      check(16'(st.detected_phase_order), 16'(PH_321));
      phase = PH_123;
      cyc(4);
      clr;
      check(16'(st.phase_inversion_error), 16'h0);
      cfg.phase_order_setting = PH_NONE;
   endtask : t_phase
   // level run held through the restart wait
   task automatic t_level;
      run = 1'b1;
      cyc(3);
      check(16'(drv.start_pulse), 16'h1);
      stop = 1'b1;
      cyc(3);
      check(16'({drv.drive_on, st.wait_restart}), 16'h1);
      stop = 1'b0;
      for (n = 0; n < 100 && !drv.start_pulse; n++) cyc(1);
      check(16'({n > 15, drv.start_pulse}), 16'h3);
      check(16'(st.wait_restart), 16'h0);
      halt;
   endtask : t_level
   // three-wire run during the wait is dropped
   task automatic t_trans;
      cfg.wire_mode = WIRE_3;
      go;
      stop = 1'b1;
      run = 1'b0;
      cyc(4);
      stop = 1'b0;
      check(16'(st.wait_restart), 16'h1);
      run = 1'b1;
      n = 0;
      repeat (50) begin
         cyc(1);
         n += int'(drv.start_pulse);
      end
      check(16'(n), 16'h0);
      run = 1'b0;
      cyc(3);
      cfg.wire_mode = WIRE_2_LEVEL;
   endtask : t_trans
   // every underload response
   task automatic t_ul;
      for (int r = 0; r < 4; r++) begin
         cfg.underload_enable = 1'b1;
         cfg.underload_detect_delay = 6'h01;
         cfg.underload_hold_time = 10'(r == 1);
         cfg.underload_response_select = ul_resp_t'(r);
         torque = 10'h04B;
         go;
         cyc(4);
         torque = 10'h00A;
         if (r > 1) begin
            for (n = 0; n < 150 && !(drv.decel_req | drv.brake_req); n++) cyc(1);
            check(16'({drv.decel_req, drv.brake_req, st.underload_error_flag}),
               16'(r == 2 ? 4 : 2));
         end
         for (n = 0; n < 150 && !(st.underload_warning_flag | st.underload_error_flag); n++) cyc(1);
         check(16'(st.underload_error_flag), 16'(r != 0));
         check(16'(drv.drive_on), 16'(r == 0));
         if (r == 0) begin
            torque = 10'h045;
            cyc(8);
            check(16'(st.underload_warning_flag), 16'h1);
            torque = 10'h047;
            cyc(6);
            check(16'(st.underload_warning_flag), 16'h0);
         end else begin
            clr;
            check(16'(st.underload_error_flag), 16'(r == 1));
            cyc(30);
            clr;
            check(16'(st.underload_error_flag), 16'h0);
         end
         torque = 10'h04B;
         halt;
      end
      cfg.underload_enable = 1'b0;
   endtask : t_ul
   // start that never reaches full voltage, coast then decelerate
   task automatic t_ls;
      cfg.start_time_limit = 10'h00A;
      for (int d = 0; d < 2; d++) begin
         cfg.long_start_response_select = d[0];
         full = 1'b0;
         go;
         for (n = 0; n < 400 && !st.long_start_error_flag; n++) cyc(1);
         check(16'({st.long_start_error_flag, drv.drive_on}), 16'h2);
         check(16'(n > 150), 16'h1);
         check(16'(st.measured_start_duration >= 10'h009), 16'h1);
         full = 1'b1;
         clr;
         halt;
      end
      cfg.start_time_limit = 10'h000;
   endtask : t_ls
   // thermal hold, braking stop and learned phase order
   task automatic t_therm;
      cfg.thermal_start_inhibit_enable = 1'b1;
      cfg.thermal_threshold = 10'h032;
      heat = 10'h3FF;
      cyc(4);
      run = 1'b1;
      cyc(10);
      check(16'({drv.drive_on, st.thermal_inhibit, st.thermal_wait_remaining}),
         16'h1E10);
      heat = 10'h010;
      go;
      check(16'(st.thermal_wait_remaining), 16'h040);
      cfg.stop_type = STOP_BRAKE;
      stop = 1'b1;
      cyc(6);
      check(16'({drv.brake_req, st.wait_restart}), 16'h2);
      cfg.stop_type = STOP_FREEWHEEL;
      halt;
      phase = PH_321;
      cyc(4);
      check(16'(st.phase_inversion_error), 16'h1);
      phase = PH_123;
      cyc(4);
      clr;
      cfg.thermal_start_inhibit_enable = 1'b0;
   endtask : t_therm
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : summarize
   //////////////////////////////
   // main sequence
   initial begin
      miscompares = 0;
      cmp_count = 0;
      {error_clear, run, stop} = 3'h0;
      full = 1'b1;
      torque = 10'h04B;
      heat = 10'h000;
      phase = PH_123;
      cfg = '0;
      cfg.underload_torque_threshold = 10'h03C;
      cfg.underload_detect_delay = 6'h3C;
      cfg.restart_delay_time = 10'h001;
      cfg.wire_mode = WIRE_2_LEVEL;
      rst = 1'b1;
      cyc(8);
      rst = 1'b0;
      cyc(1);
      check(16'({st.underload_warning_flag, st.underload_error_flag, drv}), 16'h0);
      t_phase;
      t_level;
      t_trans;
      t_ul;
      t_ls;
      t_therm;
      summarize;
   end
   // watchdog
   initial begin
      #50000;
      miscompares++;
      summarize;
   end
endmodule : motor_process_protection_monitor_tb_top
`default_nettype wire
